// ### core/pab_pkg.sv
// Constants, register map and carrier types for the PWM to converter sync.
// Assumes one 100 MHz clock and a plain address/strobe register port.
// Summary of operation
// [RULE1] A loop cycle starts on the PWM cycle-start or mid-cycle trigger.
// [RULE2] Cycle-start fires at period start; mid-cycle at the channel match.
// [RULE3] The PWM trigger reaches the delay blocks through the trigger router.
// [RULE4] Delay block a drives converter a; delay block b drives converter b.
// [RULE5] Pre-triggers pick converter channels and order by their delays.
// [RULE6] A converter starts converting on the rising edge of its trigger.
// [RULE7] A pre-trigger sets its lock; the conversion done flag releases it.
// [RULE8] No next pre-trigger is issued while a conversion is still running.
// [RULE9] Sensorless mode: commutation timer schedules and forces commutations.
// [RULE10] Hall mode: each captured edge is a commutation forcing a new sector.
// [RULE11] Hall mode: sector comes from the Hall input levels.
// [RULE12] Sensorless commutation resets the PWM counter through the router.
// [RULE13] The PWM cycle-start trigger starts both delay block counters.
// [RULE14] Counter reaching the first delay starts the first measurement.
// [RULE15] Bus current is sampled first, by the first pre-trigger of block b.
// [RULE16] Bus voltage and back-EMF are sampled together late in the pulse.
// [RULE17] Block a samples back-EMF on first; block b bus voltage on second.
// [RULE18] Results are queued in memory automatically, no CPU per sample.
// [RULE19] A completed conversion raises the interrupt output. The code raises it only for a result accepted into the queue.
// [RULE20] Hall edges restart the PWM counter and issue cycle-start too.
// [RULE21] Hall mode disables delay block a and converter a.
// [RULE22] Hall mode keeps block b measuring current and voltage as before.
// [RULE23] Back-EMF results are dropped during blanking after commutation.
package pab_pkg;

  localparam int CLK_MHZ = 100;
  localparam int CONV_TIME_NS = 1000;
  localparam int CONV_CYC = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;

  localparam int AW = 8;
  localparam int DW = 32;
  localparam int QDEPTH = 16;

  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_PWM_MOD = 8'h04;
  localparam logic [AW-1:0] A_PWM_DUTY = 8'h08;
  localparam logic [AW-1:0] A_MATCH = 8'h0c;
  localparam logic [AW-1:0] A_COMM_PER = 8'h10;
  localparam logic [AW-1:0] A_BLANK = 8'h14;
  localparam logic [AW-1:0] A_DLY_A0 = 8'h18;
  localparam logic [AW-1:0] A_DLY_B0 = 8'h1c;
  localparam logic [AW-1:0] A_DLY_B1 = 8'h20;
  localparam logic [AW-1:0] A_STATUS = 8'h24;
  localparam logic [AW-1:0] A_QDATA = 8'h28;

  localparam int C_EN = 0;
  localparam int C_HALL = 1;
  localparam int C_MID = 2;
  localparam int C_FORCE = 3;
  localparam int C_ROUTE = 4;

  localparam logic [15:0] PWM_MOD_RST = 16'h03e7;
  localparam logic [15:0] PWM_DUTY_RST = 16'h01f4;
  localparam logic [15:0] MATCH_RST = 16'h01c2;
  localparam logic [15:0] COMM_PER_RST = 16'hffff;
  localparam logic [15:0] BLANK_RST = 16'h0064;
  localparam logic [15:0] DLY_A0_RST = 16'h01a4;
  localparam logic [15:0] DLY_B0_RST = 16'h0010;
  localparam logic [15:0] DLY_B1_RST = 16'h01a4;

  localparam logic [1:0] CH_BEMF = 2'h0;
  localparam logic [1:0] CH_IBUS = 2'h1;
  localparam logic [1:0] CH_VBUS = 2'h2;
  localparam logic [2:0] SECTOR_BAD = 3'h7;

  typedef struct packed {
    logic [1:0] chan;
    logic [11:0] data;
  } pab_result_t;

  typedef struct packed {
    logic [15:0] delay0;
    logic [15:0] delay1;
  } pab_delays_t;

endpackage

// ### core/pab_sync.sv
// PWM timer, commutation/Hall timers, trigger router, two delay blocks
// with their converters, and the result queue.
// Assumes sense and Hall inputs already synchronous to clock.
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ns

module pab_pair
  import pab_pkg::*;
#(
  parameter logic [1:0] CH0 = 2'h0,
  parameter logic [1:0] CH1 = 2'h0,
  parameter logic USE2 = 1'b1
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic start,
  input wire pab_delays_t delays,
  input wire logic [11:0] sample0,
  input wire logic [11:0] sample1,
  output logic res_valid,
  output pab_result_t res,
  output logic [1:0] lock
);

  logic [15:0] cnt_q;
  logic run_q;
  logic [1:0] fired_q;
  logic [1:0] lock_q;
  logic busy_q;
  logic sel_q;
  logic [7:0] conv_q;
  logic [11:0] hold_q;
  logic valid_q;
  pab_result_t res_q;
  logic fire0;
  logic fire1;
  logic done;

  // Second pre-trigger waits for the first and for every lock to clear
  assign fire0 = run_q && enable && !fired_q[0] &&
                 cnt_q >= delays.delay0 && lock_q == 2'h0; // [RULE8] [RULE14]
  assign fire1 = run_q && enable && USE2 && fired_q[0] && !fired_q[1] &&
                 cnt_q >= delays.delay1 && lock_q == 2'h0; // [RULE5] [RULE8]
  assign done = busy_q && conv_q == 8'h00;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cnt_q <= 16'h0000;
      run_q <= 1'b0;
      fired_q <= 2'h0;
    end else if (start && enable) begin // [RULE13]
      cnt_q <= 16'h0000;
      run_q <= 1'b1;
      fired_q <= 2'h0;
    end else begin
      if (!enable) begin
        run_q <= 1'b0;
      end else if (run_q && cnt_q != 16'hffff) begin
        cnt_q <= cnt_q + 16'h0001;
      end
      if (fire0) begin
        fired_q[0] <= 1'b1;
      end
      if (fire1) begin
        fired_q[1] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      lock_q <= 2'h0;
    end else begin
      if (done) begin
        lock_q[sel_q] <= 1'b0; // [RULE7]
      end
      if (fire0) begin
        lock_q[0] <= 1'b1; // [RULE7]
      end
      if (fire1) begin
        lock_q[1] <= 1'b1; // [RULE7]
      end
    end
  end

  // Sample is held at the trigger edge so late input changes do not leak in
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      sel_q <= 1'b0;
      conv_q <= 8'h00;
      hold_q <= 12'h000;
    end else if (fire0 || fire1) begin // [RULE6]
      busy_q <= 1'b1;
      sel_q <= fire1;
      conv_q <= 8'(CONV_CYC - 1);
      hold_q <= fire1 ? sample1 : sample0; // [RULE4]
    end else if (done) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      conv_q <= conv_q - 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      valid_q <= 1'b0;
      res_q <= '0;
    end else begin
      valid_q <= done;
      if (done) begin
        res_q.chan <= sel_q ? CH1 : CH0;
        res_q.data <= hold_q;
      end
    end
  end

  assign res_valid = valid_q;
  assign res = res_q;
  assign lock = lock_q;

endmodule

module pab_sync
  import pab_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [DW-1:0] rd_data,
  input wire logic [2:0] hall_in,
  input wire logic [11:0] bemf_in,
  input wire logic [11:0] ibus_in,
  input wire logic [11:0] vbus_in,
  output logic pwm_out,
  output logic [2:0] sector,
  output logic irq
);

  logic [4:0] ctrl_q;
  logic [15:0] pwm_mod_q;
  logic [15:0] pwm_duty_q;
  logic [15:0] match_q;
  logic [15:0] comm_per_q;
  logic [15:0] blank_per_q;
  pab_delays_t dly_a_q;
  pab_delays_t dly_b_q;
  logic force_q;

  logic [15:0] comm_cnt_q;
  logic [2:0] hall_q;
  logic hall_vld_q;
  logic comm_evt;
  logic [2:0] sector_q;
  logic [15:0] blank_q;

  logic [15:0] pwm_cnt_q;
  logic cyc_start_q;
  logic mid_q;
  logic pwm_q;
  logic route_trig;
  logic delay_start;

  logic a_valid;
  logic b_valid;
  pab_result_t a_res;
  pab_result_t b_res;
  logic [1:0] a_lock;
  logic [1:0] b_lock;

  pab_result_t q_mem [QDEPTH];
  logic [3:0] wr_ptr_q;
  logic [3:0] rd_ptr_q;
  logic [4:0] q_cnt_q;
  logic acc_a;
  logic acc_b;
  logic pop;
  logic ovf_q;
  logic irq_q;
  logic [DW-1:0] rd_q;

  logic en;
  logic hall_mode;
  logic wr_hit_ctrl;

  assign en = ctrl_q[C_EN];
  assign hall_mode = ctrl_q[C_HALL];
  assign wr_hit_ctrl = wr_stb && addr == A_CTRL;

  function automatic logic [2:0] hall_sector(input logic [2:0] h);
    unique case (h)
      3'h1: hall_sector = 3'h0;
      3'h3: hall_sector = 3'h1;
      3'h2: hall_sector = 3'h2;
      3'h6: hall_sector = 3'h3;
      3'h4: hall_sector = 3'h4;
      3'h5: hall_sector = 3'h5;
      default: hall_sector = SECTOR_BAD;
    endcase
  endfunction

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl_q <= 5'h00;
      pwm_mod_q <= PWM_MOD_RST;
      pwm_duty_q <= PWM_DUTY_RST;
      match_q <= MATCH_RST;
      comm_per_q <= COMM_PER_RST;
      blank_per_q <= BLANK_RST;
      dly_a_q <= '{delay0: DLY_A0_RST, delay1: 16'h0000};
      dly_b_q <= '{delay0: DLY_B0_RST, delay1: DLY_B1_RST};
    end else if (wr_stb) begin
      unique case (addr)
        // Force bit is a command, never stored, so it reads back as 0
        A_CTRL: ctrl_q <= {wr_data[C_ROUTE], 1'b0, wr_data[C_MID:C_EN]};
        A_PWM_MOD: pwm_mod_q <= wr_data[15:0];
        A_PWM_DUTY: pwm_duty_q <= wr_data[15:0];
        A_MATCH: match_q <= wr_data[15:0]; // [RULE2]
        A_COMM_PER: comm_per_q <= wr_data[15:0];
        A_BLANK: blank_per_q <= wr_data[15:0];
        A_DLY_A0: dly_a_q.delay0 <= wr_data[15:0];
        A_DLY_B0: dly_b_q.delay0 <= wr_data[15:0];
        A_DLY_B1: dly_b_q.delay1 <= wr_data[15:0];
        default: ;
      endcase
    end
  end

  // Force is a self-clearing command bit
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      force_q <= 1'b0;
    end else begin
      force_q <= wr_hit_ctrl && wr_data[C_FORCE];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hall_q <= 3'h0;
      hall_vld_q <= 1'b0;
    end else begin
      hall_q <= hall_in;
      hall_vld_q <= 1'b1;
    end
  end

  // Either the free commutation timer or any Hall edge marks a commutation
  assign comm_evt = en && (hall_mode ?
                    (hall_vld_q && hall_q != hall_in) : // [RULE10]
                    (comm_cnt_q >= comm_per_q || force_q)); // [RULE9]

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      comm_cnt_q <= 16'h0000;
    end else if (!en || hall_mode || comm_evt) begin
      comm_cnt_q <= 16'h0000;
    end else begin
      comm_cnt_q <= comm_cnt_q + 16'h0001; // [RULE9]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sector_q <= 3'h0;
    end else if (hall_mode) begin
      sector_q <= hall_sector(hall_in); // [RULE11]
    end else if (comm_evt) begin
      sector_q <= sector_q >= 3'h5 ? 3'h0 : sector_q + 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      blank_q <= 16'h0000;
    end else if (comm_evt && !hall_mode) begin
      blank_q <= blank_per_q; // [RULE23]
    end else if (blank_q != 16'h0000) begin
      blank_q <= blank_q - 16'h0001;
    end
  end

  // Router path to the PWM timer; off means it free runs
  assign route_trig = comm_evt && ctrl_q[C_ROUTE]; // [RULE12] [RULE20]

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pwm_cnt_q <= 16'h0000;
      cyc_start_q <= 1'b0;
      mid_q <= 1'b0;
      pwm_q <= 1'b0;
    end else if (!en) begin
      pwm_cnt_q <= 16'h0000;
      cyc_start_q <= 1'b0;
      mid_q <= 1'b0;
      pwm_q <= 1'b0;
    end else begin
      if (route_trig || pwm_cnt_q >= pwm_mod_q) begin
        pwm_cnt_q <= 16'h0000; // [RULE12] [RULE20]
        cyc_start_q <= 1'b1; // [RULE2]
      end else begin
        pwm_cnt_q <= pwm_cnt_q + 16'h0001;
        cyc_start_q <= 1'b0;
      end
      mid_q <= !route_trig && pwm_cnt_q == match_q; // [RULE2]
      pwm_q <= !route_trig && pwm_cnt_q < pwm_duty_q;
    end
  end

  assign delay_start = ctrl_q[C_MID] ? mid_q : cyc_start_q; // [RULE1] [RULE3]

  pab_pair #(
    .CH0(CH_BEMF),
    .CH1(CH_BEMF),
    .USE2(1'b0)
  ) u_delay_a (
    .clock(clock),
    .rst_b(rst_b),
    .enable(en && !hall_mode), // [RULE21]
    .start(delay_start), // [RULE13]
    .delays(dly_a_q),
    .sample0(bemf_in), // [RULE16] [RULE17]
    .sample1(bemf_in),
    .res_valid(a_valid),
    .res(a_res),
    .lock(a_lock)
  );

  pab_pair #(
    .CH0(CH_IBUS),
    .CH1(CH_VBUS),
    .USE2(1'b1)
  ) u_delay_b (
    .clock(clock),
    .rst_b(rst_b),
    .enable(en), // [RULE22]
    .start(delay_start), // [RULE13]
    .delays(dly_b_q),
    .sample0(ibus_in), // [RULE15]
    .sample1(vbus_in), // [RULE16] [RULE17]
    .res_valid(b_valid),
    .res(b_res),
    .lock(b_lock)
  );

  // Space checked without counting a same-cycle pop: may drop one early
  assign acc_a = a_valid && blank_q == 16'h0000 &&
                 q_cnt_q < 5'(QDEPTH); // [RULE23] [RULE18]
  assign acc_b = b_valid &&
                 (q_cnt_q + {4'h0, acc_a}) < 5'(QDEPTH); // [RULE18]
  assign pop = rd_stb && addr == A_QDATA && q_cnt_q != 5'h00;

  always_ff @(posedge clock) begin
    if (acc_a) begin
      q_mem[wr_ptr_q] <= a_res; // [RULE18]
    end
    if (acc_b) begin
      q_mem[wr_ptr_q + {3'h0, acc_a}] <= b_res; // [RULE18]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      q_cnt_q <= 5'h00;
    end else begin
      wr_ptr_q <= wr_ptr_q + {3'h0, acc_a} + {3'h0, acc_b};
      rd_ptr_q <= rd_ptr_q + {3'h0, pop};
      q_cnt_q <= q_cnt_q + {4'h0, acc_a} + {4'h0, acc_b} - {4'h0, pop};
    end
  end

  // Status read clears the flags, but a new event in that cycle wins
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      if (rd_stb && addr == A_STATUS) begin
        irq_q <= 1'b0;
        ovf_q <= 1'b0;
      end
      if (acc_a || acc_b) begin
        irq_q <= 1'b1; // [RULE19]
      end
      if ((a_valid && blank_q == 16'h0000 && !acc_a) ||
          (b_valid && !acc_b)) begin
        ovf_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rd_q <= '0;
    end else if (rd_stb) begin
      unique case (addr)
        A_CTRL: rd_q <= {27'h0, ctrl_q};
        A_PWM_MOD: rd_q <= {16'h0, pwm_mod_q};
        A_PWM_DUTY: rd_q <= {16'h0, pwm_duty_q};
        A_MATCH: rd_q <= {16'h0, match_q};
        A_COMM_PER: rd_q <= {16'h0, comm_per_q};
        A_BLANK: rd_q <= {16'h0, blank_per_q};
        A_DLY_A0: rd_q <= {16'h0, dly_a_q.delay0};
        A_DLY_B0: rd_q <= {16'h0, dly_b_q.delay0};
        A_DLY_B1: rd_q <= {16'h0, dly_b_q.delay1};
        A_STATUS: rd_q <= {18'h0, irq_q, ovf_q, q_cnt_q,
                           sector_q, a_lock, b_lock};
        A_QDATA: rd_q <= q_cnt_q != 5'h00 ?
                         {1'b1, 17'h0, q_mem[rd_ptr_q]} : '0;
        default: rd_q <= '0;
      endcase
    end else begin
      rd_q <= '0;
    end
  end

  assign rd_data = rd_q;
  assign pwm_out = pwm_q;
  assign sector = sector_q;
  assign irq = irq_q;

endmodule

// ### tb/pab_checker.sv
// Port-level assertions for the PWM to converter sync block.
// Assumes the bus and sense inputs are driven off the rising edge.
`timescale 1ns/1ns

module pab_checker
  import pab_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [DW-1:0] rd_data,
  input wire logic [2:0] hall_in,
  input wire logic [11:0] bemf_in,
  input wire logic [11:0] ibus_in,
  input wire logic [11:0] vbus_in,
  input wire logic pwm_out,
  input wire logic [2:0] sector,
  input wire logic irq
);
  logic [4:0] ctrl_q;
  logic seen_hall_q;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl_q <= 5'h0;
    end else if (wr_stb && addr == A_CTRL) begin
      ctrl_q <= wr_data[4:0];
    end
  end
  // Sensorless range only holds until Hall mode has had the sector
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      seen_hall_q <= 1'h0;
    end else if (ctrl_q[C_HALL]) begin
      seen_hall_q <= 1'h1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  rd_idle_a: assert property (
    !$past(rd_stb) |-> rd_data == '0) else $error("read data not idle");
  ctrl_back_a: assert property (
    $past(rd_stb && addr == A_CTRL) |->
      rd_data == {27'h0, ctrl_q[4], 1'h0, ctrl_q[2:0]})
    else $error("control readback wrong");
  irq_status_a: assert property (
    $past(rd_stb && addr == A_STATUS) |->
      rd_data[13] == $past(irq) && rd_data[6:4] == $past(sector))
    else $error("status does not mirror outputs");
  irq_clear_a: assert property (
    $fell(irq) |-> $past(rd_stb && addr == A_STATUS))
    else $error("interrupt dropped without status read");
  qdata_form_a: assert property (
    $past(rd_stb && addr == A_QDATA) && rd_data[31] |->
      rd_data[30:14] == '0 && rd_data[13:12] != 2'h3)
    else $error("queue entry malformed");
  hall_bad_a: assert property (
    ctrl_q[C_HALL] && ctrl_q[C_EN] && hall_in inside {3'h0, 3'h7}
      && $stable(hall_in) |-> ##[1:2] sector == SECTOR_BAD)
    else $error("illegal hall code not flagged");
  sless_range_a: assert property (
    !seen_hall_q |-> sector < 3'h6) else $error("sector out of range");
  force_step_a: assert property (
    wr_stb && addr == A_CTRL && wr_data[C_FORCE] && wr_data[C_EN]
      && !wr_data[C_HALL] && ctrl_q[C_EN] && !seen_hall_q
      |=> ##[0:2] $changed(sector)) else $error("forced step missing");

  cover property ($rose(irq));
  cover property (rd_stb && addr == A_QDATA ##1 rd_data[31]);
  cover property (sector == SECTOR_BAD);
endmodule

bind pab_sync pab_checker i_pab_checker (.clock(clock), .rst_b(rst_b),
  .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rd_data(rd_data), .hall_in(hall_in), .bemf_in(bemf_in),
  .ibus_in(ibus_in), .vbus_in(vbus_in), .pwm_out(pwm_out),
  .sector(sector), .irq(irq));

// ### tb/pab_plant.sv
// Power stage and sense model: Hall levels and steady sense codes.
// Assumes the bench pulses step for one cycle per rotor step.
`timescale 1ns/1ns

module pab_plant #(
  parameter logic [11:0] BEMF = 12'h5a1,
  parameter logic [11:0] IBUS = 12'h2b3,
  parameter logic [11:0] VBUS = 12'h7c4
) (
  input wire logic clock,
  input wire logic step,
  input wire logic bad,
  output logic [2:0] hall_in,
  output logic [11:0] bemf_in,
  output logic [11:0] ibus_in,
  output logic [11:0] vbus_in
);
  logic [2:0] pos_q = 3'h0;
  logic [2:0] code [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  always_ff @(posedge clock) begin
    if (step) begin
      pos_q <= (pos_q == 3'h5) ? 3'h0 : pos_q + 3'h1;
    end
  end
  // A broken sensor reads all ones on every line
  assign hall_in = bad ? 3'h7 : code[pos_q];
  // Steady levels so each channel's result is known exactly
  assign bemf_in = BEMF;
  assign ibus_in = IBUS;
  assign vbus_in = VBUS;
endmodule

// ### tb/test_pab_sync.sv
// Register-level tests of the PWM to converter sync block.
// Assumes the plant model and the bound checker beside the design.
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

module test_pab_sync
  import pab_pkg::*;
;
  localparam logic [11:0] SV_B = 12'h5a1;
  localparam logic [11:0] SV_I = 12'h2b3;
  localparam logic [11:0] SV_V = 12'h7c4;
  logic clock = 1'h0;
  logic rst_b = 1'h0;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] wr_data = '0;
  logic wr_stb = 1'h0;
  logic rd_stb = 1'h0;
  logic step = 1'h0;
  logic bad = 1'h0;
  logic [DW-1:0] rd_data;
  logic [2:0] hall_in;
  logic [11:0] bemf_in;
  logic [11:0] ibus_in;
  logic [11:0] vbus_in;
  logic pwm_out;
  logic [2:0] sector;
  logic irq;
  logic [31:0] d;
  int n_mismatch = 0;
  int n_checks = 0;
  logic [7:0] ra [9] = '{A_CTRL, A_PWM_MOD, A_PWM_DUTY, A_MATCH,
    A_COMM_PER, A_BLANK, A_DLY_A0, A_DLY_B0, A_DLY_B1};
  logic [15:0] rv [9] = '{16'h0, PWM_MOD_RST, PWM_DUTY_RST, MATCH_RST,
    COMM_PER_RST, BLANK_RST, DLY_A0_RST, DLY_B0_RST, DLY_B1_RST};

  always #5 clock = ~clock;

  pab_sync i_pab_sync (.clock(clock), .rst_b(rst_b), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_data(rd_data), .hall_in(hall_in), .bemf_in(bemf_in),
    .ibus_in(ibus_in), .vbus_in(vbus_in), .pwm_out(pwm_out),
    .sector(sector), .irq(irq));
  pab_plant #(.BEMF(SV_B), .IBUS(SV_I), .VBUS(SV_V)) i_pab_plant (
    .clock(clock), .step(step), .bad(bad), .hall_in(hall_in),
    .bemf_in(bemf_in), .ibus_in(ibus_in), .vbus_in(vbus_in));

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    addr <= a;
    wr_data <= v;
    wr_stb <= 1'h1;
    @(posedge clock);
    wr_stb <= 1'h0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'h1;
    @(posedge clock);
    rd_stb <= 1'h0;
    #1 v = rd_data;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    `CHK(v, e)
  endtask
  function automatic logic [31:0] qv(input logic [1:0] c,
                                      input logic [11:0] v);
    return {1'h1, 17'h0, c, v};
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    idle(20000);
    n_mismatch++;
    summarize();
  end

  initial begin
    idle(12);
    rst_b <= 1'h1;
    for (int i = 0; i < 9; i++) begin
      rdc(ra[i], {16'h0, rv[i]});
    end
    rdc(8'h2c, 32'h0);
    wr(A_STATUS, '1);
    rdc(A_STATUS, 32'h0);
    $display("test registers done");
    // Sensorless: first cycle-start comes at the counter wrap
    wr(A_CTRL, 32'h1);
    idle(1060);
    rd(A_STATUS, d);
    `CHK(d[3:0], 4'h1)
    idle(700);
    wr(A_CTRL, 32'h0);
    rdc(A_STATUS, 32'h2180);
    `CHK(irq, 1'h0)
    rdc(A_QDATA, qv(CH_IBUS, SV_I));
    rdc(A_QDATA, qv(CH_BEMF, SV_B));
    rdc(A_QDATA, qv(CH_VBUS, SV_V));
    rdc(A_QDATA, 32'h0);
    $display("test sensorless done");
    // Forced commutation restarts the cycle inside a long blanking
    wr(A_BLANK, 32'h2ff);
    wr(A_CTRL, 32'h11);
    wr(A_CTRL, 32'h19);
    rdc(A_CTRL, 32'h11);
    idle(700);
    wr(A_CTRL, 32'h0);
    rdc(A_STATUS, 32'h2110);
    rdc(A_QDATA, qv(CH_IBUS, SV_I));
    rdc(A_QDATA, qv(CH_VBUS, SV_V));
    rdc(A_QDATA, 32'h0);
    $display("test forced done");
    // Hall: close second pre-trigger must wait for the first lock
    wr(A_DLY_B1, 32'h11);
    rdc(A_DLY_B1, 32'h11);
    wr(A_CTRL, 32'h13);
    idle(700);
    #1;
    `CHK(pwm_out, 1'h0)
    @(posedge clock);
    step <= 1'h1;
    @(posedge clock);
    step <= 1'h0;
    idle(6);
    #1;
    `CHK(pwm_out, 1'h1)
    idle(300);
    bad <= 1'h1;
    idle(4);
    #1;
    `CHK(sector, SECTOR_BAD)
    idle(300);
    wr(A_CTRL, 32'h0);
    rdc(A_QDATA, qv(CH_IBUS, SV_I));
    rdc(A_QDATA, qv(CH_VBUS, SV_V));
    // The broken-sensor code is a Hall change too, so one more cycle ran
    rdc(A_QDATA, qv(CH_IBUS, SV_I));
    rdc(A_QDATA, qv(CH_VBUS, SV_V));
    for (int i = 0; i < 4; i++) begin
      rdc(A_QDATA, 32'h0);
    end
    $display("test hall done");
    // Mid-cycle match starts the delay blocks, not the period wrap
    wr(A_CTRL, 32'h5);
    idle(480);
    rd(A_STATUS, d);
    `CHK(d[3:0], 4'h1)
    wr(A_CTRL, 32'h0);
    idle(100);
    rdc(A_QDATA, qv(CH_IBUS, SV_I));
    rdc(A_QDATA, 32'h0);
    $display("test mid done");
    summarize();
  end
endmodule
